/* File: src/serial_ctrl_pkg.sv */
// constants and types shared by the two-wire serial bus controller
package serial_ctrl_pkg;

   // system clock rate and bus-free (stop to start) interval per speed mode
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned T_BUF_STD_NS = 4700;
   localparam int unsigned T_BUF_FAST_NS = 1300;
   localparam int unsigned BUF_STD_CYC = (T_BUF_STD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned BUF_FAST_CYC = (T_BUF_FAST_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam logic [7:0] BUF_STD_LEN = 8'(BUF_STD_CYC);
   localparam logic [7:0] BUF_FAST_LEN = 8'(BUF_FAST_CYC);

   // bit period in system clocks is the divider value plus this offset
   localparam int unsigned DIV_OFFSET = 4;

   // bit positions within a byte slot: 0..7 data, 8 acknowledge
   localparam logic [3:0] DATA_LAST = 4'h7;
   localparam logic [3:0] ACK_SLOT = 4'h8;

   // address patterns
   localparam logic [4:0] TEN_BIT_TAG = 5'h1E;
   localparam logic [7:0] GENERAL_CALL = 8'h00;

   // phases of a master slot
   localparam logic [1:0] PH_LOW0 = 2'h0;
   localparam logic [1:0] PH_RISE = 2'h2;
   localparam logic [1:0] PH_HIGH = 2'h3;

   typedef enum logic [1:0] {
      OP_START = 2'h0,
      OP_WRITE = 2'h1,
      OP_READ = 2'h2,
      OP_STOP = 2'h3
   } cmd_op_t;

   typedef enum logic [2:0] {
      M_IDLE = 3'h0,
      M_START = 3'h1,
      M_BIT = 3'h3,
      M_HOLD = 3'h2,
      M_STOP = 3'h6
   } m_state_t;

   typedef enum logic [2:0] {
      SL_IDLE = 3'h0,
      SL_ADDR = 3'h1,
      SL_ADDR2 = 3'h3,
      SL_RX = 3'h2,
      SL_TX = 3'h6
   } s_state_t;

   typedef enum logic [2:0] {
      ROLE_NONE = 3'h0,
      ROLE_MTX = 3'h1,
      ROLE_MRX = 3'h3,
      ROLE_STX = 3'h2,
      ROLE_SRX = 3'h6
   } role_t;

endpackage

/* File: src/two_wire_multi_master_serial.sv */
// two-wire multi-master serial bus controller: master and slave engines
// What this block does
// - drive both lines only low or released
// - release both lines when nothing transfers
// - normal and fast speed modes by configuration
// - master or slave, transmitter or receiver roles
// - 7/10-bit own address plus general call
// - master starts, clocks and ends each transfer
// - one clock pulse per data bit
// - data changes only while clock low
// - start: data falls while clock high
// - stop: data rises while clock high
// - busy after start, free after interval
// - released one read low means collision
// - losing master stops driving data at once
// - clock follows wired-and of all masters
// - held-low clock stretches master timing
// - bit period from divider and fast select
// - serial byte transfers in both directions
// - line sampled many times per clock period
// - eight bits msb first plus ack slot
// - receiver holds data low for ack
// - address then direction bit after start
// - lost address arbitration leaves slave listening
`timescale 1ns/1ps
`default_nettype none

module two_wire_multi_master_serial #(
   parameter int unsigned DIV_W = 10
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_scl,
   output logic o_scl_o,
   output logic o_scl_oe,
   input wire logic i_sda,
   output logic o_sda_o,
   output logic o_sda_oe,
   input wire logic i_fast_mode,
   input wire logic [DIV_W-1:0] i_baud_divider_value,
   input wire logic [9:0] i_own_addr,
   input wire logic i_addr_10bit,
   input wire logic i_gc_enable,
   input wire logic i_cmd_valid,
   input wire serial_ctrl_pkg::cmd_op_t i_cmd_op,
   input wire logic [7:0] i_cmd_data,
   input wire logic i_cmd_last,
   output logic o_cmd_ready,
   output logic o_byte_done,
   output logic o_nack,
   output logic o_arb_lost,
   output logic o_bus_busy,
   output serial_ctrl_pkg::role_t o_role,
   input wire logic i_tx_valid,
   input wire logic [7:0] i_tx_data,
   output logic o_tx_ready,
   output logic o_dma_tx_req,
   output logic o_rx_valid,
   output logic [7:0] o_rx_data,
   input wire logic i_rx_ready,
   output logic o_dma_rx_req
);

   generate
      if (DIV_W < 3 || DIV_W > 16) begin : g_bad_div
         $error("divider width must be 3 to 16");
      end
   endgenerate

   logic [2:0] scl_sync, sda_sync;
   logic scl_f, sda_f, scl_d, sda_d;
   logic [7:0] free_cnt;
   logic free_run;
   serial_ctrl_pkg::m_state_t m_st;
   logic [1:0] m_ph;
   logic [DIV_W+1:0] m_cnt;
   logic [3:0] m_bit;
   logic [8:0] m_sh;
   logic [7:0] m_rx;
   logic m_tx, m_sda_low;
   serial_ctrl_pkg::s_state_t s_st;
   logic [3:0] s_bit;
   logic [7:0] s_sh, s_tsh;
   logic s_sda_low, s_wait, s_m10;
   logic t_valid;
   logic [7:0] t_data;

   // filtered line levels and bus conditions
   wire scl_rise = scl_f & ~scl_d;
   wire scl_fall = ~scl_f & scl_d;
   wire start_det = scl_f & scl_d & sda_d & ~sda_f;
   wire stop_det = scl_f & scl_d & ~sda_d & sda_f;

   // timing from divider; fast mode shortens high part
   wire [DIV_W:0] period = {1'b0, i_baud_divider_value} + (DIV_W+1)'(serial_ctrl_pkg::DIV_OFFSET);
   wire [DIV_W:0] q_len = i_fast_mode ? period / (DIV_W+1)'(3) : period >> 2;
   wire [DIV_W+1:0] high_len = i_fast_mode ? {1'b0, q_len} : {q_len, 1'b0};
   wire [7:0] buf_len = i_fast_mode ? serial_ctrl_pkg::BUF_FAST_LEN : serial_ctrl_pkg::BUF_STD_LEN;

   // master decode
   wire m_slot = m_st == serial_ctrl_pkg::M_START || m_st == serial_ctrl_pkg::M_BIT ||
      m_st == serial_ctrl_pkg::M_STOP;
   wire m_cnt_done = m_cnt == '0;
   wire m_high_end = m_slot && m_ph == serial_ctrl_pkg::PH_HIGH && (m_cnt_done || !scl_f);
   wire m_lose = m_st == serial_ctrl_pkg::M_BIT && m_ph == serial_ctrl_pkg::PH_RISE && scl_f &&
      m_tx && m_bit != serial_ctrl_pkg::ACK_SLOT && m_sh[8] && !sda_f;
   wire m_push = m_st == serial_ctrl_pkg::M_BIT && m_high_end &&
      m_bit == serial_ctrl_pkg::ACK_SLOT && !m_tx;
   wire m_scl_low = (m_slot && m_ph < serial_ctrl_pkg::PH_RISE) || m_st == serial_ctrl_pkg::M_HOLD;
   wire cmd_take = o_cmd_ready & i_cmd_valid;

   // slave decode
   wire s_gc = i_gc_enable && s_sh == serial_ctrl_pkg::GENERAL_CALL;
   wire s_hit7 = !i_addr_10bit && s_sh[7:1] == i_own_addr[6:0];
   wire s_hdr10 = i_addr_10bit && s_sh[7:3] == serial_ctrl_pkg::TEN_BIT_TAG && s_sh[2:1] == i_own_addr[9:8];
   wire s_act = (scl_fall | s_wait) && s_st != serial_ctrl_pkg::SL_IDLE;
   wire tx_take = o_tx_ready & i_tx_valid;

   // receive buffer decode
   wire rx_pop = o_rx_valid & i_rx_ready;
   wire rx_full = o_rx_valid & t_valid;
   wire s_push = s_act && s_st == serial_ctrl_pkg::SL_RX && s_bit == serial_ctrl_pkg::DATA_LAST && !rx_full;
   wire push = m_push | s_push;
   wire [7:0] push_byte = m_push ? m_rx : s_sh;
   wire next_rx_valid = (o_rx_valid & ~rx_pop) | t_valid | push;

   wire serial_ctrl_pkg::role_t next_role = m_st != serial_ctrl_pkg::M_IDLE ?
      (m_tx ? serial_ctrl_pkg::ROLE_MTX : serial_ctrl_pkg::ROLE_MRX) :
      s_st == serial_ctrl_pkg::SL_TX ? serial_ctrl_pkg::ROLE_STX :
      s_st == serial_ctrl_pkg::SL_RX ? serial_ctrl_pkg::ROLE_SRX : serial_ctrl_pkg::ROLE_NONE;

   // lines sampled every system clock, far above bit rate
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         scl_sync <= 3'h7;
         sda_sync <= 3'h7;
         scl_f <= 1'b1;
         sda_f <= 1'b1;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[1:0], i_scl};
         sda_sync <= {sda_sync[1:0], i_sda};
         if (scl_sync[1] == scl_sync[2]) begin
            scl_f <= scl_sync[2];
         end
         if (sda_sync[1] == sda_sync[2]) begin
            sda_f <= sda_sync[2];
         end
         scl_d <= scl_f;
         sda_d <= sda_f;
      end
   end

   // busy on start, free after interval following stop
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_bus_busy <= 1'b0;
         free_cnt <= 8'h00;
         free_run <= 1'b0;
      end else if (start_det) begin
         o_bus_busy <= 1'b1;
         free_run <= 1'b0;
      end else if (stop_det) begin
         free_run <= 1'b1;
         free_cnt <= buf_len;
      end else if (free_run) begin
         free_cnt <= free_cnt - 8'h01;
         if (free_cnt == 8'h00) begin
            o_bus_busy <= 1'b0;
            free_run <= 1'b0;
         end
      end
   end

   // master engine: each slot is low, low, rise-wait, high; a start from idle begins at rise-wait
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         m_st <= serial_ctrl_pkg::M_IDLE;
         m_ph <= serial_ctrl_pkg::PH_LOW0;
         m_cnt <= '0;
         m_bit <= 4'h0;
         m_sh <= 9'h1FF;
         m_rx <= 8'h00;
         m_tx <= 1'b0;
         m_sda_low <= 1'b0;
         o_nack <= 1'b0;
         o_byte_done <= 1'b0;
         o_arb_lost <= 1'b0;
      end else begin
         o_byte_done <= 1'b0;
         o_arb_lost <= 1'b0;
         if (!m_slot) begin
            if (cmd_take && i_cmd_op == serial_ctrl_pkg::OP_STOP && m_st == serial_ctrl_pkg::M_HOLD) begin
               m_st <= serial_ctrl_pkg::M_STOP;
               m_ph <= serial_ctrl_pkg::PH_LOW0;
               m_cnt <= {1'b0, q_len};
            end else if (cmd_take && i_cmd_op == serial_ctrl_pkg::OP_START) begin
               // start then address byte with direction bit
               m_st <= serial_ctrl_pkg::M_START;
               m_ph <= m_st == serial_ctrl_pkg::M_IDLE ? serial_ctrl_pkg::PH_RISE : serial_ctrl_pkg::PH_LOW0;
               m_cnt <= {1'b0, q_len};
               m_sh <= {i_cmd_data, 1'b1};
               m_tx <= 1'b1;
            end else if (cmd_take && m_st == serial_ctrl_pkg::M_HOLD && i_cmd_op != serial_ctrl_pkg::OP_STOP) begin
               // byte plus ack slot, msb first
               m_st <= serial_ctrl_pkg::M_BIT;
               m_ph <= serial_ctrl_pkg::PH_LOW0;
               m_cnt <= {1'b0, q_len};
               m_bit <= 4'h0;
               m_tx <= i_cmd_op == serial_ctrl_pkg::OP_WRITE;
               m_sh <= i_cmd_op == serial_ctrl_pkg::OP_WRITE ? {i_cmd_data, 1'b1} : {8'hFF, i_cmd_last};
            end
         end else if (m_lose) begin
            // slave engine keeps decoding the winner's address
            m_st <= serial_ctrl_pkg::M_IDLE;
            m_sda_low <= 1'b0;
            o_arb_lost <= 1'b1;
         end else if (m_ph < serial_ctrl_pkg::PH_RISE) begin
            if (m_cnt_done) begin
               m_ph <= m_ph + 2'h1;
               m_cnt <= {1'b0, q_len};
               // data moves mid-low, never beside the clock edge
               if (m_ph == serial_ctrl_pkg::PH_LOW0) begin
                  m_sda_low <= m_st == serial_ctrl_pkg::M_BIT ? ~m_sh[8] : m_st == serial_ctrl_pkg::M_STOP;
               end
            end else begin
               m_cnt <= m_cnt - (DIV_W+2)'(1);
            end
         end else if (m_ph == serial_ctrl_pkg::PH_RISE) begin
            // wait until the wired clock really rises
            if (scl_f) begin
               m_ph <= serial_ctrl_pkg::PH_HIGH;
               m_cnt <= high_len;
               // start: pull data low while clock high
               // stop: release data while clock high
               if (m_st == serial_ctrl_pkg::M_START) begin
                  m_sda_low <= 1'b1;
               end else if (m_st == serial_ctrl_pkg::M_STOP) begin
                  m_sda_low <= 1'b0;
               end else if (m_bit != serial_ctrl_pkg::ACK_SLOT) begin
                  m_rx <= {m_rx[6:0], sda_f};
               end else if (m_tx) begin
                  o_nack <= sda_f;
               end
            end
         end else if (m_high_end) begin
            // one clock pulse ends each slot
            m_ph <= serial_ctrl_pkg::PH_LOW0;
            m_cnt <= {1'b0, q_len};
            if (m_st == serial_ctrl_pkg::M_START) begin
               m_st <= serial_ctrl_pkg::M_BIT;
               m_bit <= 4'h0;
            end else if (m_st == serial_ctrl_pkg::M_STOP) begin
               m_st <= serial_ctrl_pkg::M_IDLE;
            end else begin
               m_sh <= {m_sh[7:0], 1'b1};
               m_bit <= m_bit + 4'h1;
               if (m_bit == serial_ctrl_pkg::ACK_SLOT) begin
                  m_st <= serial_ctrl_pkg::M_HOLD;
                  o_byte_done <= 1'b1;
               end
            end
         end else begin
            m_cnt <= m_cnt - (DIV_W+2)'(1);
         end
      end
   end

   // slave engine: sample on clock rise, drive after clock fall
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         s_st <= serial_ctrl_pkg::SL_IDLE;
         s_bit <= 4'h0;
         s_sh <= 8'h00;
         s_tsh <= 8'h00;
         s_sda_low <= 1'b0;
         s_wait <= 1'b0;
         s_m10 <= 1'b0;
         o_tx_ready <= 1'b0;
         o_dma_tx_req <= 1'b0;
      end else if (start_det || stop_det) begin
         s_st <= start_det ? serial_ctrl_pkg::SL_ADDR : serial_ctrl_pkg::SL_IDLE;
         s_bit <= start_det ? serial_ctrl_pkg::ACK_SLOT : 4'h0;
         s_sda_low <= 1'b0;
         s_wait <= 1'b0;
         s_m10 <= s_m10 & start_det;
         o_tx_ready <= 1'b0;
         o_dma_tx_req <= 1'b0;
      end else begin
         if (scl_rise && s_st != serial_ctrl_pkg::SL_IDLE) begin
            if (s_bit != serial_ctrl_pkg::ACK_SLOT) begin
               s_sh <= {s_sh[6:0], sda_f};
            end else if (s_st == serial_ctrl_pkg::SL_TX && sda_f) begin
               s_st <= serial_ctrl_pkg::SL_IDLE;
            end
         end
         if (s_act && s_bit == serial_ctrl_pkg::DATA_LAST) begin
            s_bit <= serial_ctrl_pkg::ACK_SLOT;
            s_sda_low <= 1'b1;
            // own 7-bit, 10-bit header/low byte, general call
            case (s_st)
               serial_ctrl_pkg::SL_ADDR: begin
                  if (s_gc || s_hit7) begin
                     s_st <= s_sh[0] && !s_gc ? serial_ctrl_pkg::SL_TX : serial_ctrl_pkg::SL_RX;
                  end else if (s_hdr10 && (!s_sh[0] || s_m10)) begin
                     s_st <= s_sh[0] ? serial_ctrl_pkg::SL_TX : serial_ctrl_pkg::SL_ADDR2;
                  end else begin
                     s_st <= serial_ctrl_pkg::SL_IDLE;
                     s_sda_low <= 1'b0;
                  end
               end
               serial_ctrl_pkg::SL_ADDR2: begin
                  s_m10 <= s_sh == i_own_addr[7:0];
                  s_st <= s_sh == i_own_addr[7:0] ? serial_ctrl_pkg::SL_RX : serial_ctrl_pkg::SL_IDLE;
                  s_sda_low <= s_sh == i_own_addr[7:0];
               end
               serial_ctrl_pkg::SL_RX: begin
                  // ack only once the byte has a place; stretch till then
                  s_wait <= rx_full;
                  s_sda_low <= !rx_full;
                  s_bit <= rx_full ? s_bit : serial_ctrl_pkg::ACK_SLOT;
               end
               default: begin
                  s_sda_low <= 1'b0;
               end
            endcase
         end else if (s_act && s_bit == serial_ctrl_pkg::ACK_SLOT) begin
            if (s_st != serial_ctrl_pkg::SL_TX) begin
               s_sda_low <= 1'b0;
               s_bit <= 4'h0;
            end else if (tx_take) begin
               // byte handed over by the dma channel or software
               s_tsh <= {i_tx_data[6:0], 1'b0};
               s_sda_low <= ~i_tx_data[7];
               s_bit <= 4'h0;
               s_wait <= 1'b0;
               o_tx_ready <= 1'b0;
               o_dma_tx_req <= 1'b0;
            end else begin
               s_wait <= 1'b1;
               o_tx_ready <= 1'b1;
               o_dma_tx_req <= 1'b1;
            end
         end else if (s_act) begin
            s_bit <= s_bit + 4'h1;
            if (s_st == serial_ctrl_pkg::SL_TX) begin
               s_sda_low <= ~s_tsh[7];
               s_tsh <= {s_tsh[6:0], 1'b0};
            end
         end
      end
   end

   // two-entry receive buffer, so a late reader loses no byte
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_rx_valid <= 1'b0;
         o_rx_data <= 8'h00;
         o_dma_rx_req <= 1'b0;
         t_valid <= 1'b0;
         t_data <= 8'h00;
      end else begin
         o_rx_valid <= next_rx_valid;
         o_dma_rx_req <= next_rx_valid;
         if (!o_rx_valid || rx_pop) begin
            o_rx_data <= t_valid ? t_data : (push ? push_byte : o_rx_data);
            t_valid <= t_valid & push;
            t_data <= push ? push_byte : t_data;
         end else if (push) begin
            t_valid <= 1'b1;
            t_data <= push_byte;
         end
      end
   end

   // pin drivers and reported state
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_scl_o <= 1'b0;
         o_sda_o <= 1'b0;
         o_scl_oe <= 1'b0;
         o_sda_oe <= 1'b0;
         o_cmd_ready <= 1'b0;
         o_role <= serial_ctrl_pkg::ROLE_NONE;
      end else begin
         // open drain: only pull low, else release
         o_scl_o <= 1'b0;
         o_sda_o <= 1'b0;
         o_scl_oe <= m_scl_low | s_wait;
         o_sda_oe <= m_sda_low | s_sda_low;
         // ready one cycle late; a start from idle waits for a free bus
         o_cmd_ready <= ~cmd_take & ((m_st == serial_ctrl_pkg::M_IDLE & ~o_bus_busy & ~start_det) |
            (m_st == serial_ctrl_pkg::M_HOLD & ~rx_full));
         o_role <= next_role;
      end
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   sequence bit_slot_end;
      m_st == serial_ctrl_pkg::M_BIT && m_high_end && m_bit != serial_ctrl_pkg::ACK_SLOT;
   endsequence
   sequence rise_waiting;
      m_slot && m_ph == serial_ctrl_pkg::PH_RISE && !scl_f;
   endsequence

   pins_open_drain_a: assert property (!o_sda_o && !o_scl_o)
      else $error("bus pin driven high");
   idle_release_a: assert property (m_st == serial_ctrl_pkg::M_IDLE && s_st == serial_ctrl_pkg::SL_IDLE
      && !s_wait |=> !o_scl_oe && !o_sda_oe)
      else $error("line held while idle");
   one_pulse_bit_a: assert property (bit_slot_end |=> m_bit == $past(m_bit) + 4'h1
      && m_ph == serial_ctrl_pkg::PH_LOW0)
      else $error("bit slot count wrong");
   data_stable_a: assert property (m_st == serial_ctrl_pkg::M_BIT && m_ph == serial_ctrl_pkg::PH_HIGH
      |-> $stable(m_sda_low))
      else $error("data moved while clock high");
   start_form_a: assert property (m_st == serial_ctrl_pkg::M_START && m_ph == serial_ctrl_pkg::PH_HIGH
      |-> m_sda_low ##1 o_sda_oe)
      else $error("start not formed");
   stop_form_a: assert property (m_st == serial_ctrl_pkg::M_STOP && m_ph == serial_ctrl_pkg::PH_HIGH
      |-> !m_sda_low && !m_scl_low)
      else $error("stop not formed");
   busy_start_a: assert property (start_det |=> o_bus_busy [*8])
      else $error("busy not held after start");
   arb_release_a: assert property (m_lose |=> o_arb_lost && m_st == serial_ctrl_pkg::M_IDLE
      && !m_sda_low)
      else $error("lost master still driving");
   stretch_wait_a: assert property (rise_waiting |=> m_ph == serial_ctrl_pkg::PH_RISE)
      else $error("master ran on while clock held");
   ack_hold_a: assert property (s_st == serial_ctrl_pkg::SL_RX && s_bit == serial_ctrl_pkg::ACK_SLOT
      |-> s_sda_low)
      else $error("receiver ack missing");
   sync_filter_a: assert property ($changed(scl_f) |-> scl_f == $past(scl_sync[2]))
      else $error("clock level taken before settling");

endmodule // two_wire_multi_master_serial

`default_nettype wire

/* File: test/bus_slave_model.sv */
// slave device model on the far side of the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module bus_slave_model #(
   parameter logic [6:0] ADDR = 7'h2A
) (
   input wire logic i_clk_sys,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic [7:0] i_tx_byte,
   input wire logic [7:0] i_stretch,
   output logic o_scl_oe,
   output logic o_sda_oe,
   output logic [7:0] o_rx_byte,
   output logic o_mack
);
   logic pscl = 1'b1, psda = 1'b1, sel = 1'b0, rd = 1'b0, adr = 1'b0;
   logic [3:0] cnt = 4'h0;
   logic [7:0] sh = 8'h00, tx = 8'h00, hold = 8'h00;
   wire logic hit = (sh[7:1] == ADDR);
   initial begin
      o_scl_oe = 1'b0;
      o_sda_oe = 1'b0;
      o_rx_byte = 8'h00;
      o_mack = 1'b0;
   end
   always @(posedge i_clk_sys) begin
      pscl <= i_scl;
      psda <= i_sda;
      if (hold != 8'h00) begin
         hold <= hold - 8'h01;
         o_scl_oe <= (hold != 8'h01);
      end
      if (i_scl && pscl && (psda != i_sda)) begin
         cnt <= 4'h0;
         adr <= !i_sda;
         sel <= 1'b0;
         o_sda_oe <= 1'b0;
      end else if (!pscl && i_scl) begin
         // msb first, ninth pulse is ack
         if (cnt != 4'h8) begin
            sh <= {sh[6:0], i_sda};
         end else if (sel && rd) begin
            o_mack <= !i_sda;
            sel <= !i_sda;
         end
         cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
      end else if (pscl && !i_scl) begin
         // data moves only while clock low
         o_sda_oe <= (cnt == 4'h8) && (adr ? hit : sel && !rd);
         if (cnt == 4'h8 && adr) begin
            sel <= hit;
            rd <= sh[0];
            adr <= 1'b0;
         end
         if (cnt == 4'h8 && sel && !rd && !adr) o_rx_byte <= sh;
         // next read byte latched before its first bit goes out
         if (cnt == 4'h8) tx <= i_tx_byte;
         if (cnt < 4'h8 && sel && rd) o_sda_oe <= !tx[3'(4'h7 - cnt)];
         // slow slave holds clock after ack
         if (cnt == 4'h0 && sel && i_stretch != 8'h00) begin
            o_scl_oe <= 1'b1;
            hold <= i_stretch;
         end
      end
   end
endmodule // bus_slave_model
`default_nettype wire

/* File: test/tb_top.sv */
// self-checking bench: controller as bus master against a slave model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [6:0] SADDR = 7'h2A;
   logic clk = 1'b0, rst = 1'b1, fast = 1'b0, valid = 1'b0, last = 1'b0, rxr = 1'b0, pull = 1'b0, gce = 1'b0;
   logic pscl = 1'b1, psda = 1'b1;
   logic [9:0] div = 10'h024;
   logic [7:0] data = 8'h00, txb = 8'h00, stretch = 8'h00, mrx, rxd;
   logic [7:0] ex [2];
   logic [7:0] q [$];
   logic [31:0] seed = 32'h00017484;
   serial_ctrl_pkg::cmd_op_t op = serial_ctrl_pkg::OP_START;
   serial_ctrl_pkg::role_t role;
   logic ready, bdone, nack, arb, busy, rxv, dma, mack, d_scl_oe, d_sda_oe, m_scl_oe, m_sda_oe, txr, dtx;
   int error_cnt = 0, checked = 0, starts = 0, stops = 0, nst = 0, nsp = 0, n;
   // pull-ups turn the enables into a wired-and
   wire logic scl = ~(d_scl_oe | m_scl_oe);
   wire logic sda = ~(d_sda_oe | m_sda_oe | pull);
   two_wire_multi_master_serial #(.DIV_W(10)) two_wire_multi_master_serial_inst (
      .i_clk_sys(clk), .i_rst(rst), .i_scl(scl), .o_scl_o(), .o_scl_oe(d_scl_oe), .i_sda(sda), .o_sda_o(),
      .o_sda_oe(d_sda_oe), .i_fast_mode(fast), .i_baud_divider_value(div), .i_own_addr(10'h033),
      .i_addr_10bit(1'b0), .i_gc_enable(gce), .i_cmd_valid(valid), .i_cmd_op(op), .i_cmd_data(data),
      .i_cmd_last(last), .o_cmd_ready(ready), .o_byte_done(bdone), .o_nack(nack), .o_arb_lost(arb),
      .o_bus_busy(busy), .o_role(role), .i_tx_valid(txr), .i_tx_data(txb), .o_tx_ready(txr),
      .o_dma_tx_req(dtx), .o_rx_valid(rxv), .o_rx_data(rxd), .i_rx_ready(rxr), .o_dma_rx_req(dma));
   bus_slave_model #(.ADDR(SADDR)) bus_slave_model_inst (
      .i_clk_sys(clk), .i_scl(scl), .i_sda(sda), .i_tx_byte(txb), .i_stretch(stretch),
      .o_scl_oe(m_scl_oe), .o_sda_oe(m_sda_oe), .o_rx_byte(mrx), .o_mack(mack));
   always #50 clk = ~clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %0h exp %0h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      if (error_cnt == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic cmd(input serial_ctrl_pkg::cmd_op_t o, input logic [7:0] d, input logic l, input logic w);
      int k;
      @(negedge clk);
      op = o;
      data = d;
      last = l;
      valid = 1'b1;
      for (k = 0; k < 3000 && ready !== 1'b1; k++) @(negedge clk);
      if (k >= 3000) error_cnt++;
      @(negedge clk);
      valid = 1'b0;
      nst += (o == serial_ctrl_pkg::OP_START);
      nsp += (o == serial_ctrl_pkg::OP_STOP);
      for (k = 0; w && k < 3000 && bdone !== 1'b1; k++) @(negedge clk);
      if (k >= 3000) error_cnt++;
   endtask
   task automatic stop_bus();
      cmd(serial_ctrl_pkg::OP_STOP, 8'h00, 1'b0, 1'b0);
      for (n = 0; n < 900 && busy !== 1'b0; n++) @(negedge clk);
      chk({busy, d_scl_oe, d_sda_oe}, 3'h0);
   endtask
   // receiver stalls at random so some bytes wait in the buffer a while
   always @(negedge clk) begin
      seed <= lfsr(seed);
      rxr <= seed[0] | seed[3];
   end
   always @(posedge clk) begin
      pscl <= scl;
      psda <= sda;
      if (scl && pscl && psda && !sda) starts++;
      if (scl && pscl && !psda && sda) stops++;
      if (rxv === 1'b1 && rxr) q.push_back(rxd);
      if (!rst) chk({dma, dtx}, {rxv, txr});
   end
   initial begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      chk({busy, d_scl_oe, d_sda_oe}, 3'h0);
      for (int m = 0; m < 2; m++) begin
         fast = m[0];
         div = m[0] ? 10'h01B : 10'h024;
         stretch = m[0] ? 8'h00 : 8'h3C;
         cmd(serial_ctrl_pkg::OP_START, {SADDR, 1'b0}, 1'b0, 1'b1);
         chk({busy, nack}, 2'h2);
         for (int k = 0; k < 2; k++) begin
            ex[0] = seed[15:8];
            cmd(serial_ctrl_pkg::OP_WRITE, ex[0], 1'b0, 1'b1);
            chk({mrx, nack}, {ex[0], 1'b0});
            chk(role, serial_ctrl_pkg::ROLE_MTX);
         end
         ex[0] = seed[7:0];
         ex[1] = seed[23:16];
         txb = ex[0];
         cmd(serial_ctrl_pkg::OP_START, {SADDR, 1'b1}, 1'b0, 1'b1);
         txb = ex[1];
         for (int k = 0; k < 2; k++) begin
            cmd(serial_ctrl_pkg::OP_READ, 8'h00, k[0], 1'b1);
            chk({mack, role}, {~k[0], serial_ctrl_pkg::ROLE_MRX});
            for (n = 0; n < 900 && q.size() == 0; n++) @(negedge clk);
            chk(q.size() > 0 ? {1'b0, q.pop_front()} : 9'h100, {1'b0, ex[k]});
         end
         stop_bus();
      end
      // general call reaches our own slave, which acks it
      gce = 1'b1;
      cmd(serial_ctrl_pkg::OP_START, 8'h00, 1'b0, 1'b1);
      chk(nack, 1'b0);
      stop_bus();
      // our master reads one byte from our own slave address
      txb = seed[31:24];
      cmd(serial_ctrl_pkg::OP_START, {7'h33, 1'b1}, 1'b0, 1'b1);
      chk(nack, 1'b0);
      cmd(serial_ctrl_pkg::OP_READ, 8'h00, 1'b1, 1'b1);
      for (n = 0; n < 900 && q.size() == 0; n++) @(negedge clk);
      chk(q.size() > 0 ? {1'b0, q.pop_front()} : 9'h100, {1'b0, txb});
      stop_bus();
      // nobody answers this address
      cmd(serial_ctrl_pkg::OP_START, 8'h22, 1'b0, 1'b1);
      chk(nack, 1'b1);
      stop_bus();
      // a rival master holds data low while ours sends a one
      cmd(serial_ctrl_pkg::OP_START, 8'hF0, 1'b0, 1'b0);
      for (n = 0; n < 900 && d_scl_oe !== 1'b1; n++) @(negedge clk);
      pull = 1'b1;
      for (n = 0; n < 900 && arb !== 1'b1; n++) @(negedge clk);
      chk(arb, 1'b1);
      @(negedge clk);
      chk(d_sda_oe, 1'b0);
      for (n = 0; n < 900 && scl !== 1'b1; n++) @(negedge clk);
      pull = 1'b0;
      nsp++;
      for (n = 0; n < 900 && busy !== 1'b0; n++) @(negedge clk);
      chk(busy, 1'b0);
      chk(starts, nst);
      chk(stops, nsp);
      test_done();
   end
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      test_done();
   end
endmodule // tb_top
`default_nettype wire
